// File: logic/psp_pkg.sv
// psp_pkg: widths, register map, field positions and reset values
// for the serial-programmed synthesizer control block.
// assumes a 32-bit axi4-lite bus with byte addresses of 8 bits.
package psp_pkg;
    // serial register widths
    localparam int          MAIN_W        = 20;
    localparam int          EXT_W         = 8;
    // bus geometry
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          STRB_W        = 4;
    // register byte addresses
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_MAIN     = 8'h04;
    localparam logic [7:0]  ADDR_HOLD     = 8'h08;
    localparam logic [7:0]  ADDR_EXT      = 8'h0c;
    localparam logic [7:0]  ADDR_STAT     = 8'h10;
    localparam logic [7:0]  ADDR_PROG     = 8'h14;
    // control register fields
    localparam int          CTRL_W        = 3;
    localparam int          CTRL_OVR_EN   = 0;
    localparam int          CTRL_OVR_SEL  = 1;
    localparam int          CTRL_PD_EN    = 2;
    localparam logic [2:0]  CTRL_RST      = 3'h4;
    // status register fields
    localparam int          STAT_W        = 6;
    localparam int          STAT_LOCKED   = 0;
    localparam int          STAT_UP       = 1;
    localparam int          STAT_DOWN     = 2;
    localparam int          STAT_STROBE   = 3;
    localparam int          STAT_EXTMODE  = 4;
    localparam int          STAT_SRC      = 5;
    // bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // idle levels of the pins at reset
    localparam logic [5:0]  PIN_IDLE      = 6'h14;
endpackage : psp_pkg

// File: logic/psp_sync.sv
// psp_sync: two-stage synchroniser for a group of pin levels.
// assumes each bit is a slow level; no bus coherence is promised.
`timescale 1ns/1ns
module psp_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         mclk,    // block clock
    input  wire logic         reset_n, // synchronous reset, active low
    input  wire logic [W-1:0] async_i, // raw pin levels
    output logic      [W-1:0] sync_o   // levels in the mclk domain
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            meta_q <= INIT;
            sync_o <= INIT;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : psp_sync

// File: logic/psp_pfd.sv
// psp_pfd: phase-frequency detector with active-low pulse outputs,
// their nand filter node and the open-drain lock indicator enable.
// assumes both comparison inputs are already synchronised to mclk.
`timescale 1ns/1ns
module psp_pfd
    import psp_pkg::*;
(
    input  wire logic mclk,        // block clock
    input  wire logic reset_n,     // synchronous reset, active low
    input  wire logic enable,      // detector enable
    input  wire logic main_s,      // main-divider comparison, synced
    input  wire logic ref_s,       // reference comparison, synced
    output logic      up_n_q,      // up pulse, active low
    output logic      down_n_q,    // down pulse, active low
    output logic      filter_q,    // nand of the two pulses
    output logic      lock_oe_n_q  // lock pin driven low when low
);
    logic main_d1_q;
    logic ref_d1_q;
    logic main_rise;
    logic ref_rise;
    logic up_set;
    logic down_set;
    logic up_n_d;
    logic down_n_d;
    logic filter_d;

    // edges of the comparison signals
    assign main_rise = main_s & ~main_d1_q;
    assign ref_rise  = ref_s & ~ref_d1_q;
    // a pulse holds until the lagging edge arrives, then both clear
    assign up_set    = ~up_n_q | ref_rise;
    assign down_set  = ~down_n_q | main_rise;
    assign up_n_d    = ~(enable & up_set & ~down_set);
    assign down_n_d  = ~(enable & down_set & ~up_set);
    assign filter_d  = ~(up_n_d & down_n_d);

    // detector state and pin flops
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            main_d1_q   <= 1'b0;
            ref_d1_q    <= 1'b0;
            up_n_q      <= 1'b1;
            down_n_q    <= 1'b1;
            filter_q    <= 1'b0;
            lock_oe_n_q <= 1'b1;
        end else begin
            main_d1_q   <= main_s;
            ref_d1_q    <= ref_s;
            up_n_q      <= up_n_d;
            down_n_q    <= down_n_d;
            filter_q    <= filter_d;
            lock_oe_n_q <= ~filter_d;
        end
    end

    // checks on the detector outputs
    property p_up_on_ref_lead;
        @(posedge mclk) disable iff (!reset_n)
        enable && ref_rise && !main_rise && down_n_q |=> !up_n_q;
    endproperty
    a_up_on_ref_lead: assert property (p_up_on_ref_lead)
        else $error("up pulse missing after reference lead");

    property p_down_on_main_lead;
        @(posedge mclk) disable iff (!reset_n)
        enable && main_rise && !ref_rise && up_n_q |=> !down_n_q;
    endproperty
    a_down_on_main_lead: assert property (p_down_on_main_lead)
        else $error("down pulse missing after main lead");

    property p_filter_nand;
        @(posedge mclk) disable iff (!reset_n)
        filter_q == ~(up_n_q & down_n_q);
    endproperty
    a_filter_nand: assert property (p_filter_nand)
        else $error("filter node is not nand of pulses");

    property p_lock_drive;
        @(posedge mclk) disable iff (!reset_n)
        (!up_n_q || !down_n_q) |-> !lock_oe_n_q ##0 filter_q;
    endproperty
    a_lock_drive: assert property (p_lock_drive)
        else $error("lock pin not driven while out of lock");

    c_up_pulse: cover property (@(posedge mclk) disable iff (!reset_n)
        !up_n_q ##1 up_n_q);
endmodule : psp_pfd

// File: logic/psp_top.sv
// psp_top: serial programming port, counter word select and phase
// detector of an integer-n synthesizer, with an axi4-lite slave.
// assumes pins arrive asynchronous to mclk; serial clock is slow
// against mclk (well over four mclk periods per level).
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module psp_top
    import psp_pkg::*;
(
    input  wire logic              mclk,                  // block clock
    input  wire logic              reset_n,               // sync reset
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,          // write address
    input  wire logic              s_axi_awvalid,         // aw valid
    output logic                   s_axi_awready,         // aw ready
    input  wire logic [DATA_W-1:0] s_axi_wdata,           // write data
    input  wire logic [STRB_W-1:0] s_axi_wstrb,           // byte enables
    input  wire logic              s_axi_wvalid,          // w valid
    output logic                   s_axi_wready,          // w ready
    output logic [1:0]             s_axi_bresp,           // write resp
    output logic                   s_axi_bvalid,          // b valid
    input  wire logic              s_axi_bready,          // b ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,          // read address
    input  wire logic              s_axi_arvalid,         // ar valid
    output logic                   s_axi_arready,         // ar ready
    output logic [DATA_W-1:0]      s_axi_rdata,           // read data
    output logic [1:0]             s_axi_rresp,           // read resp
    output logic                   s_axi_rvalid,          // r valid
    input  wire logic              s_axi_rready,          // r ready
    input  wire logic              serial_clk,            // shift clock pin
    input  wire logic              serial_data,           // serial data pin
    input  wire logic              load_strobe,           // load strobe pin
    input  wire logic              ext_write_en,          // ext reg select
    input  wire logic              ext_mode_n,            // ext mode, low on
    input  wire logic              counter_source_select, // 1 main, 0 hold
    input  wire logic              main_cmp,              // main divider out
    input  wire logic              ref_cmp,               // ref divider out
    output logic                   phase_up_pulse_n,      // up pulse
    output logic                   phase_down_pulse_n,    // down pulse
    output logic                   filter_node,           // pulse nand
    output logic                   lock_indicator_o,      // lock pin level
    output logic                   lock_indicator_oe_n,   // lock pin enable
    output logic                   aux_data_out,          // aux data pin
    output logic [MAIN_W-1:0]      counter_word,          // counter program
    output logic [EXT_W-1:0]       ext_word               // effective ext bits
);
    logic [5:0]        pins_s;
    logic              sclk_s;
    logic              sdata_s;
    logic              strobe_s;
    logic              ewr_s;
    logic              extn_s;
    logic              sel_s;
    logic [1:0]        cmp_s;
    logic              sclk_d1_q;
    logic              strobe_d1_q;
    logic              sclk_rise;
    logic              strobe_rise;
    logic              shift_main;
    logic              shift_ext;
    logic              sel_eff;
    logic [MAIN_W-1:0] main_q;
    logic [MAIN_W-1:0] hold_q;
    logic [EXT_W-1:0]  ext_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [DATA_W-1:0] w_data_q;
    logic [STRB_W-1:0] w_strb_q;
    logic              aw_got_q;
    logic              w_got_q;
    logic              wr_fire;
    logic              wr_ctrl;
    logic [STAT_W-1:0] status;
    logic [DATA_W-1:0] rd_mux;

    // true for every address the slave answers with okay
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == ADDR_CTRL) || (a == ADDR_MAIN) ||
                    (a == ADDR_HOLD) || (a == ADDR_EXT)  ||
                    (a == ADDR_STAT) || (a == ADDR_PROG);
    endfunction : is_mapped

    // pin synchronisers, one group for the serial port and mode pins
    psp_sync #(
        .W    (6),
        .INIT (PIN_IDLE)
    ) u_pin_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .async_i ({counter_source_select, ext_mode_n, ext_write_en,
                   load_strobe, serial_data, serial_clk}),
        .sync_o  (pins_s)
    );

    // synchronisers for the divider comparison signals
    psp_sync #(
        .W    (2),
        .INIT (2'h0)
    ) u_cmp_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .async_i ({ref_cmp, main_cmp}),
        .sync_o  (cmp_s)
    );

    assign sclk_s   = pins_s[0];
    assign sdata_s  = pins_s[1];
    assign strobe_s = pins_s[2];
    assign ewr_s    = pins_s[3];
    assign extn_s   = pins_s[4];
    assign sel_s    = pins_s[5];

    // edges of shift clock and strobe, and shift routing
    assign sclk_rise   = sclk_s & ~sclk_d1_q;
    assign strobe_rise = strobe_s & ~strobe_d1_q;
    assign shift_main  = sclk_rise & ~strobe_s & ~ewr_s;
    assign shift_ext   = sclk_rise & ~strobe_s & ewr_s;
    assign sel_eff     = ctrl_q[CTRL_OVR_EN] ? ctrl_q[CTRL_OVR_SEL] : sel_s;

    // edge history
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sclk_d1_q   <= 1'b0;
            strobe_d1_q <= 1'b1;
        end else begin
            sclk_d1_q   <= sclk_s;
            strobe_d1_q <= strobe_s;
        end
    end

    // serial shift registers, first bit ends at the top
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            main_q <= '0;
            ext_q  <= '0;
        end else begin
            if (shift_main)
                main_q <= {main_q[MAIN_W-2:0], sdata_s};
            if (shift_ext)
                ext_q <= {ext_q[EXT_W-2:0], sdata_s};
        end
    end

    // holding register loads only on strobe rise
    always_ff @(posedge mclk) begin
        if (!reset_n)
            hold_q <= '0;
        else if (strobe_rise)
            hold_q <= main_q;
    end

    // programming word, effective extension bits and aux output
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            counter_word     <= '0;
            ext_word         <= '0;
            aux_data_out     <= 1'b0;
            lock_indicator_o <= 1'b0;
        end else begin
            counter_word     <= sel_eff ? main_q : hold_q;
            ext_word         <= extn_s ? '0 : ext_q;
            aux_data_out     <= ~extn_s & main_q[MAIN_W-1];
            lock_indicator_o <= 1'b0;
        end
    end

    // phase detector and lock outputs
    psp_pfd u_pfd (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .enable      (ctrl_q[CTRL_PD_EN]),
        .main_s      (cmp_s[0]),
        .ref_s       (cmp_s[1]),
        .up_n_q      (phase_up_pulse_n),
        .down_n_q    (phase_down_pulse_n),
        .filter_q    (filter_node),
        .lock_oe_n_q (lock_indicator_oe_n)
    );

    // write channel: address and data taken in either order
    assign wr_fire = aw_got_q & w_got_q;
    assign wr_ctrl = wr_fire & (aw_addr_q == ADDR_CTRL) & w_strb_q[0];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            aw_addr_q     <= '0;
            w_data_q      <= '0;
            w_strb_q      <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q     <= s_axi_awaddr;
                aw_got_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                w_got_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_addr_q) ? RESP_OKAY
                                                     : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // control register, low byte only
    always_ff @(posedge mclk) begin
        if (!reset_n)
            ctrl_q <= CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= w_data_q[CTRL_W-1:0];
    end

    // status and read selection
    assign status[STAT_LOCKED]  = ~filter_node;
    assign status[STAT_UP]      = ~phase_up_pulse_n;
    assign status[STAT_DOWN]    = ~phase_down_pulse_n;
    assign status[STAT_STROBE]  = strobe_s;
    assign status[STAT_EXTMODE] = ~extn_s;
    assign status[STAT_SRC]     = sel_eff;
    assign rd_mux =
        (s_axi_araddr == ADDR_CTRL) ? DATA_W'(ctrl_q)       :
        (s_axi_araddr == ADDR_MAIN) ? DATA_W'(main_q)       :
        (s_axi_araddr == ADDR_HOLD) ? DATA_W'(hold_q)       :
        (s_axi_araddr == ADDR_EXT)  ? DATA_W'(ext_q)        :
        (s_axi_araddr == ADDR_STAT) ? DATA_W'(status)       :
        (s_axi_araddr == ADDR_PROG) ? DATA_W'(counter_word) : '0;

    // read channel, one transfer at a time
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= is_mapped(s_axi_araddr) ? RESP_OKAY
                                                     : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks on the serial port, counter word and write response
    property p_shift_main;
        @(posedge mclk) disable iff (!reset_n)
        shift_main |=> main_q == {$past(main_q[MAIN_W-2:0]), $past(sdata_s)}
                       && $stable(ext_q);
    endproperty
    a_shift_main: assert property (p_shift_main)
        else $error("main register did not shift");

    property p_shift_ext;
        @(posedge mclk) disable iff (!reset_n)
        shift_ext |=> ext_q == {$past(ext_q[EXT_W-2:0]), $past(sdata_s)}
                      && $stable(main_q);
    endproperty
    a_shift_ext: assert property (p_shift_ext)
        else $error("extension register did not shift");

    property p_strobe_high_blocks;
        @(posedge mclk) disable iff (!reset_n)
        strobe_s |=> $stable(main_q) && $stable(ext_q);
    endproperty
    a_strobe_high_blocks: assert property (p_strobe_high_blocks)
        else $error("bits accepted while strobe high");

    property p_load;
        @(posedge mclk) disable iff (!reset_n)
        strobe_rise |=> hold_q == $past(main_q);
    endproperty
    a_load: assert property (p_load)
        else $error("holding register missed the load");

    property p_hold_keep;
        @(posedge mclk) disable iff (!reset_n)
        !strobe_rise |=> $stable(hold_q);
    endproperty
    a_hold_keep: assert property (p_hold_keep)
        else $error("holding register changed without strobe");

    property p_select;
        @(posedge mclk) disable iff (!reset_n)
        1'b1 |=> counter_word == ($past(sel_eff) ? $past(main_q)
                                                 : $past(hold_q));
    endproperty
    a_select: assert property (p_select)
        else $error("counter word from wrong source");

    property p_ext_gate;
        @(posedge mclk) disable iff (!reset_n)
        extn_s |=> ext_word == '0 && !aux_data_out;
    endproperty
    a_ext_gate: assert property (p_ext_gate)
        else $error("extension bits active outside extension mode");

    property p_bresp_hold;
        @(posedge mclk) disable iff (!reset_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response dropped early");

    c_load: cover property (@(posedge mclk) disable iff (!reset_n)
        shift_main ##[1:200] strobe_rise);
    c_ext: cover property (@(posedge mclk) disable iff (!reset_n)
        shift_ext && !extn_s);
    c_read: cover property (@(posedge mclk) disable iff (!reset_n)
        s_axi_rvalid && s_axi_rready);
endmodule : psp_top

// File: testbench/psp_host.sv
// psp_host: host model driving the three-wire serial programming port.
// assumes a 125 ns shift clock that stands low between frames.
`timescale 1ns/1ns
module psp_host (
    output logic serial_clk,  // shift clock
    output logic serial_data, // serial data
    output logic load_strobe, // load strobe, low while shifting
    output logic ext_write_en // high selects the extension register
);
    // idle levels at time zero
    initial begin
        serial_clk   = 1'b0;
        serial_data  = 1'b0;
        load_strobe  = 1'b1;
        ext_write_en = 1'b0;
    end

    // shift n bits of w; gate low keeps the strobe high throughout
    task automatic send(input logic [19:0] w, input int n, input logic ext,
                        input logic gate, input logic rise);
        load_strobe  = !gate;
        ext_write_en = ext;
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = w[i];
            #30 serial_clk = 1'b1;
            #32 serial_data = !serial_data; // data no longer held
            #31 serial_clk = 1'b0;
            #32;
        end
        #8 ext_write_en = 1'b0;
        if (rise)
            load_strobe = 1'b1;
        #40;
    endtask : send
endmodule : psp_host

// File: testbench/psp_top_test.sv
// psp_top_test: self-checking bench for psp_top with a bit-level model.
// assumes the psp_pkg register map and the psp_host serial model.
`timescale 1ns/1ns
module psp_top_test
    import psp_pkg::*;
;
    logic              mclk = 1'b0, reset_n = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rv;
    logic [STRB_W-1:0] s_axi_wstrb = 4'hf;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic              s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic              s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
    logic              serial_clk, serial_data, load_strobe, ext_write_en;
    logic              ext_mode_n = 1'b1, counter_source_select = 1'b0;
    logic              main_cmp = 1'b0, ref_cmp = 1'b0, aux_data_out;
    logic              phase_up_pulse_n, phase_down_pulse_n, filter_node;
    logic              lock_indicator_o, lock_indicator_oe_n;
    logic [MAIN_W-1:0] counter_word, main_m = '0, hold_m = '0, w;
    logic [EXT_W-1:0]  ext_word, ext_m = '0;
    int                bad_count = 0, check_count = 0;

    // design and serial host
    psp_top psp_top_inst (
        .mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .serial_clk, .serial_data,
        .load_strobe, .ext_write_en, .ext_mode_n, .counter_source_select,
        .main_cmp, .ref_cmp, .phase_up_pulse_n, .phase_down_pulse_n,
        .filter_node, .lock_indicator_o, .lock_indicator_oe_n,
        .aux_data_out, .counter_word, .ext_word
    );
    psp_host psp_host_inst (
        .serial_clk, .serial_data, .load_strobe, .ext_write_en
    );

    // block clock, 8 ns period
    always #4 mclk = !mclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // one write; address and data released independently when taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (n >= 200)
            bad_count++;
    endtask : wr

    // one read, then compare data and response
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        int n = 0;
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'b0;
        if (n >= 200)
            bad_count++;
        check(s_axi_rdata, e);
        check(32'(s_axi_rresp), 32'(er));
    endtask : rchk

    // send a frame and update the reference model alike
    task automatic frame(input logic [19:0] v, input int n, input logic ext,
                         input logic gate, input logic rise);
        bit q[$];
        for (int i = n - 1; i >= 0; i--)
            q.push_back(v[i]);
        psp_host_inst.send(v, n, ext, gate, rise);
        while (gate && q.size() > 0)
            if (ext)
                ext_m = {ext_m[EXT_W-2:0], q.pop_front()};
            else
                main_m = {main_m[MAIN_W-2:0], q.pop_front()};
        if (gate && rise)
            hold_m = main_m;
        repeat (10) @(posedge mclk);
    endtask : frame

    // r high: reference rises first, else main rises first
    task automatic phase(input logic r);
        ref_cmp  <= r;
        main_cmp <= !r;
        repeat (10) @(posedge mclk);
        check(32'(phase_up_pulse_n), 32'(!r));
        check(32'(phase_down_pulse_n), 32'(r));
        check(32'(filter_node), 32'h1);
        check(32'({lock_indicator_oe_n, lock_indicator_o}), 32'h0);
        ref_cmp  <= 1'b1;
        main_cmp <= 1'b1;
        repeat (10) @(posedge mclk);
        check(32'({phase_up_pulse_n, phase_down_pulse_n}), 32'h3);
        check(32'(filter_node), 32'h0);
        check(32'({lock_indicator_oe_n, lock_indicator_o}), 32'h2);
        ref_cmp  <= 1'b0;
        main_cmp <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask : phase

    // main sequence
    initial begin
        void'($urandom(32'h2583));
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rchk(ADDR_CTRL, 32'(CTRL_RST), RESP_OKAY);
        rchk(8'h40, 32'h0, RESP_SLVERR);
        w = 20'($urandom);
        frame(w, 20, 1'b0, 1'b1, 1'b1);
        rchk(ADDR_MAIN, 32'(main_m), RESP_OKAY);
        rchk(ADDR_HOLD, 32'(hold_m), RESP_OKAY);
        check(32'(counter_word), 32'(hold_m));
        frame(~w, 20, 1'b0, 1'b1, 1'b0);
        rchk(ADDR_HOLD, 32'(hold_m), RESP_OKAY);
        check(32'(counter_word), 32'(hold_m));
        counter_source_select <= 1'b1;
        repeat (8) @(posedge mclk);
        check(32'(counter_word), 32'(main_m));
        rchk(ADDR_PROG, 32'(main_m), RESP_OKAY);
        counter_source_select <= 1'b0;
        wr(ADDR_CTRL, 32'h3);
        ref_cmp <= 1'b1;
        repeat (8) @(posedge mclk);
        check(32'(counter_word), 32'(main_m));
        check(32'({phase_up_pulse_n, phase_down_pulse_n}), 32'h3);
        ref_cmp <= 1'b0;
        wr(ADDR_MAIN, 32'h0);
        check(32'(resp), 32'(RESP_OKAY));
        wr(8'h40, 32'h0);
        check(32'(resp), 32'(RESP_SLVERR));
        wr(ADDR_CTRL, 32'(CTRL_RST));
        s_axi_wstrb <= 4'h0;
        wr(ADDR_CTRL, 32'h0);
        s_axi_wstrb <= 4'hf;
        rchk(ADDR_CTRL, 32'(CTRL_RST), RESP_OKAY);
        frame(20'h0, 0, 1'b0, 1'b1, 1'b1);
        check(32'(counter_word), 32'(hold_m));
        frame(w, 20, 1'b0, 1'b0, 1'b1);
        rchk(ADDR_MAIN, 32'(main_m), RESP_OKAY);
        frame(w, 8, 1'b1, 1'b1, 1'b1);
        rchk(ADDR_EXT, 32'(ext_m), RESP_OKAY);
        check(32'({ext_word, aux_data_out}), 32'h0);
        ext_mode_n <= 1'b0;
        repeat (8) @(posedge mclk);
        check(32'(ext_word), 32'(ext_m));
        check(32'(aux_data_out), 32'(main_m[MAIN_W-1]));
        frame(~w, 8, 1'b1, 1'b1, 1'b1);
        check(32'(ext_word), 32'(ext_m));
        phase(1'b1);
        phase(1'b0);
        rchk(ADDR_STAT, 32'((1 << STAT_LOCKED) | (1 << STAT_STROBE)
                            | (1 << STAT_EXTMODE)), RESP_OKAY);
        final_report;
    end

    // watchdog against a hung handshake
    initial begin
        #200000;
        bad_count++;
        final_report;
    end
endmodule : psp_top_test
